/* design/ast_baud_gen.sv */
// divisor counter that makes one oversample tick per period
`timescale 1ns/1ps
module ast_baud_gen (
  input wire logic CLOCK,
  input wire logic RST,
  ast_baud_if.gen  bif
);
  logic [15:0] cnt_q;
  logic [15:0] top;
  // narrow divisor uses only the low byte
  assign top = bif.wide ? bif.divisor : {8'h00, bif.divisor[7:0]};
  always_ff @(posedge CLOCK) begin
    if (RST || !bif.run) begin
      cnt_q    <= 16'h0000;
      bif.tick <= 1'b0;
    end else if (cnt_q >= top) begin
      cnt_q    <= 16'h0000;
      bif.tick <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 16'h0001;
      bif.tick <= 1'b0;
    end
  end
endmodule : ast_baud_gen

/* design/ast_baud_if.sv */
// baud tick link between the generator and the transmitter
`timescale 1ns/1ps
interface ast_baud_if;
  logic        run;
  logic        wide;
  logic        fast;
  logic [15:0] divisor;
  logic        tick;
  modport gen (input run, input wide, input fast, input divisor, output tick);
  modport user (output run, output wide, output fast, output divisor, input tick);
endinterface : ast_baud_if

/* design/ast_cfg.svh */
// register map, field positions, reset values and timing counts for the serial transmitter
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_ADDR_W          3
`define AST_OFF_TXCTL       3'h0
`define AST_OFF_RATECTL     3'h1
`define AST_OFF_DIVLO       3'h2
`define AST_OFF_DIVHI       3'h3
`define AST_OFF_HOLD        3'h4
`define AST_OFF_FLAGS       3'h5
`define AST_OFF_PIE         3'h6
`define AST_OFF_IRQCTL      3'h7
`define AST_TX_NINE         6
`define AST_TX_EN           5
`define AST_TX_SYNC         4
`define AST_TX_HSPEED       2
`define AST_TX_SHEMPTY      1
`define AST_TX_NINTHD       0
`define AST_RC_RXINV        5
`define AST_RC_IDLEPOL      4
`define AST_RC_WIDE         3
`define AST_RC_PORTEN       7
`define AST_FL_TXEMPTY      4
`define AST_PIE_TRANSMIT_IRQ_ENABLE        4
`define AST_IC_GLOBAL       7
`define AST_IC_PERIPH       6
`define AST_TXCTL_RST       8'h02
`define AST_RATECTL_RST     8'h00
`define AST_OVS_FAST        16
`define AST_OVS_SLOW        64
`define AST_FLAG_SETTLE     2
`endif

/* design/ast_pkg.sv */
// types shared by the serial transmitter modules
package ast_pkg;
  typedef enum logic [1:0] {
    AST_IDLE  = 2'b00,
    AST_START = 2'b01,
    AST_DATA  = 2'b11,
    AST_STOP  = 2'b10
  } ast_state_t;
endpackage : ast_pkg

/* design/ast_tx.sv */
// asynchronous serial transmitter with register port and shared baud generator
`timescale 1ns/1ps
`include "ast_cfg.svh"
// Contract
// - clocked-mode select cleared means asynchronous operation
// - frame is start bit, eight or nine data bits, one stop bit
// - data goes out least significant bit first
// - transmit and receive share frame format and baud rate
// - 8 or 16 bit divisor, tick at x16 or x64 bit rate
// - no hardware parity; ninth bit comes from software
// - timing pin idles high when polarity bit set, else low
// - receive invert bit inverts incoming data
// - shifter reloads only after stop bit, then at once if word pending
// - buffer to shifter move takes one cycle, then empty flag sets
// - empty flag sets regardless of enable, software cannot clear it; here it sets only on transmit enable rising or on a load
// - empty flag clears and is valid by second cycle after write
// - read-only shifter empty bit, no interrupt
// - shifter is not visible in the register map
// - setting transmit enable sets empty flag
// - interrupt needs global and peripheral enables
// - port enable cleared holds port in reset
module ast_tx (
  input  wire logic                   CLOCK,
  input  wire logic                   RST,
  input  wire logic [`AST_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [7:0]             RDATA,
  input  wire logic                   RX_PIN,
  output logic                        RX_DATA,
  output logic                        TX_PIN,
  output logic                        TX_OE,
  output logic                        TIMING_PIN,
  output logic                        IRQ
);
  logic [7:0]  txctl_q;
  logic [7:0]  ratectl_q;
  logic [7:0]  divlo_q;
  logic [7:0]  divhi_q;
  logic [7:0]  pie_q;
  logic [7:0]  irqctl_q;
  logic [8:0]  hold_q;
  logic        hold_full_q;
  logic        empty_flag_q;
  logic [1:0]  settle_q;
  logic [8:0]  shift_q;
  logic [3:0]  bit_cnt_q;
  logic [5:0]  ovs_q;
  logic        load_q;
  logic [1:0]  rx_sync_q;
  ast_pkg::ast_state_t state_q;
  logic        port_on;
  logic        tx_on;
  logic        bit_end;
  logic        hold_wr;
  logic        en_rise;
  logic        prev_en_q;
  logic        frame_done;
  logic [5:0]  ovs_top;
  logic [3:0]  last_bit;

  ast_baud_if bif ();

  function automatic logic is_wr(input logic [`AST_ADDR_W-1:0] off);
    is_wr = WR && (ADDR == off);
  endfunction : is_wr

  assign port_on  = ratectl_q[`AST_RC_PORTEN] && !txctl_q[`AST_TX_SYNC];
  assign tx_on    = port_on && txctl_q[`AST_TX_EN];
  assign hold_wr  = is_wr(`AST_OFF_HOLD);
  assign en_rise  = txctl_q[`AST_TX_EN] && !prev_en_q;
  // x16 when wide or high-speed chosen, x64 otherwise
  assign ovs_top  = (ratectl_q[`AST_RC_WIDE] || txctl_q[`AST_TX_HSPEED]) ?
                    6'(`AST_OVS_FAST - 1) : 6'(`AST_OVS_SLOW - 1);
  assign bit_end  = bif.tick && (ovs_q == ovs_top);
  assign last_bit = txctl_q[`AST_TX_NINE] ? 4'h8 : 4'h7;
  assign frame_done = (state_q == ast_pkg::AST_STOP) && bit_end;

  assign bif.run     = port_on;
  assign bif.wide    = ratectl_q[`AST_RC_WIDE];
  assign bif.fast    = txctl_q[`AST_TX_HSPEED];
  assign bif.divisor = {divhi_q, divlo_q};

  ast_baud_gen u_baud (
    .CLOCK (CLOCK),
    .RST   (RST),
    .bif   (bif)
  );

  // configuration registers; the shifter has no address of its own
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      txctl_q   <= `AST_TXCTL_RST;
      ratectl_q <= `AST_RATECTL_RST;
      divlo_q   <= 8'h00;
      divhi_q   <= 8'h00;
      pie_q     <= 8'h00;
      irqctl_q  <= 8'h00;
      prev_en_q <= 1'b0;
    end else begin
      prev_en_q <= txctl_q[`AST_TX_EN];
      // shifter empty bit is read-only, kept out of writes
      if (is_wr(`AST_OFF_TXCTL))
        txctl_q <= {WDATA[7:2], txctl_q[`AST_TX_SHEMPTY], WDATA[0]};
      else
        txctl_q[`AST_TX_SHEMPTY] <= (state_q == ast_pkg::AST_IDLE) && !load_q;
      if (is_wr(`AST_OFF_RATECTL))
        ratectl_q <= WDATA;
      if (is_wr(`AST_OFF_DIVLO))
        divlo_q <= WDATA;
      if (is_wr(`AST_OFF_DIVHI))
        divhi_q <= WDATA;
      if (is_wr(`AST_OFF_PIE))
        pie_q <= WDATA;
      if (is_wr(`AST_OFF_IRQCTL))
        irqctl_q <= WDATA;
    end
  end

  // holding buffer; ninth bit latched from control at write time
  always_ff @(posedge CLOCK) begin
    if (RST || !port_on) begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end else if (hold_wr) begin
      hold_q      <= {txctl_q[`AST_TX_NINTHD], WDATA};
      hold_full_q <= 1'b1;
    end else if (load_q) begin
      hold_full_q <= 1'b0;
    end
  end

  // flag drops one cycle late on purpose, mirroring pipeline latency
  always_ff @(posedge CLOCK) begin
    if (RST || !port_on) begin
      settle_q     <= 2'b00;
      empty_flag_q <= 1'b0;
    end else begin
      settle_q <= {settle_q[0], hold_wr};
      if (en_rise || (load_q && !hold_wr))
        empty_flag_q <= 1'b1;
      else if (settle_q[0])
        empty_flag_q <= 1'b0;
    end
  end

  // load pulse: one cycle transfer from buffer into shifter
  always_ff @(posedge CLOCK) begin
    if (RST || !tx_on)
      load_q <= 1'b0;
    else
      load_q <= hold_full_q && !load_q && !settle_q[0] && !settle_q[1] &&
                ((state_q == ast_pkg::AST_IDLE) || frame_done);
  end

  // frame sequencer
  always_ff @(posedge CLOCK) begin
    if (RST || !tx_on) begin
      state_q   <= ast_pkg::AST_IDLE;
      shift_q   <= 9'h000;
      bit_cnt_q <= 4'h0;
      ovs_q     <= 6'h00;
    end else begin
      if (bif.tick)
        ovs_q <= (ovs_q == ovs_top) ? 6'h00 : ovs_q + 6'h01;
      case (state_q)
        ast_pkg::AST_IDLE: begin
          ovs_q <= 6'h00;
          if (load_q) begin
            shift_q   <= hold_q;
            bit_cnt_q <= 4'h0;
            state_q   <= ast_pkg::AST_START;
          end
        end
        ast_pkg::AST_START: begin
          if (bit_end)
            state_q <= ast_pkg::AST_DATA;
        end
        ast_pkg::AST_DATA: begin
          if (bit_end) begin
            shift_q   <= {1'b0, shift_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == last_bit)
              state_q <= ast_pkg::AST_STOP;
          end
        end
        ast_pkg::AST_STOP: begin
          if (bit_end)
            state_q <= ast_pkg::AST_IDLE;
        end
        default: state_q <= ast_pkg::AST_IDLE;
      endcase
    end
  end

  // pins and interrupt, all registered
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      TX_PIN     <= 1'b1;
      TX_OE      <= 1'b0;
      TIMING_PIN <= 1'b0;
      IRQ        <= 1'b0;
      rx_sync_q  <= 2'b11;
      RX_DATA    <= 1'b1;
    end else begin
      TX_OE <= port_on;
      case (state_q)
        ast_pkg::AST_START: TX_PIN <= 1'b0;
        ast_pkg::AST_DATA:  TX_PIN <= shift_q[0];
        default:            TX_PIN <= 1'b1;
      endcase
      TIMING_PIN <= ratectl_q[`AST_RC_IDLEPOL];
      IRQ <= empty_flag_q && pie_q[`AST_PIE_TRANSMIT_IRQ_ENABLE] &&
             irqctl_q[`AST_IC_GLOBAL] && irqctl_q[`AST_IC_PERIPH];
      rx_sync_q <= {rx_sync_q[0], RX_PIN};
      RX_DATA   <= rx_sync_q[1] ^ ratectl_q[`AST_RC_RXINV];
    end
  end

  // read port; the holding buffer reads back its last value
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `AST_OFF_TXCTL:   RDATA <= txctl_q;
        `AST_OFF_RATECTL: RDATA <= ratectl_q;
        `AST_OFF_DIVLO:   RDATA <= divlo_q;
        `AST_OFF_DIVHI:   RDATA <= divhi_q;
        `AST_OFF_HOLD:    RDATA <= hold_q[7:0];
        `AST_OFF_FLAGS:   RDATA <= 8'(empty_flag_q) << `AST_FL_TXEMPTY;
        `AST_OFF_PIE:     RDATA <= pie_q;
        `AST_OFF_IRQCTL:  RDATA <= irqctl_q;
        default:          RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  a_stop_mark: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q == ast_pkg::AST_STOP) |=> TX_PIN) else $error("stop bit not mark");
  a_start_space: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q == ast_pkg::AST_START) |=> !TX_PIN) else $error("start bit not space");
  a_no_midframe: assert property (@(posedge CLOCK) disable iff (RST)
    load_q |-> (state_q == ast_pkg::AST_IDLE) || frame_done) else $error("reload mid frame");
  a_load_flag: assert property (@(posedge CLOCK) disable iff (RST)
    load_q && port_on && !hold_wr |=> empty_flag_q) else $error("flag not set on load");
  a_en_flag: assert property (@(posedge CLOCK) disable iff (RST)
    en_rise && port_on |=> empty_flag_q) else $error("enable did not set flag");
  a_flag_clear: assert property (@(posedge CLOCK) disable iff (RST)
    hold_wr && port_on && !load_q ##1 !load_q && port_on |=> !empty_flag_q)
    else $error("flag not cleared after write");
  a_idle_pol: assert property (@(posedge CLOCK) disable iff (RST)
    ##1 $stable(ratectl_q) |=> TIMING_PIN == $past(ratectl_q[`AST_RC_IDLEPOL]))
    else $error("timing pin idle wrong");
  a_irq_gate: assert property (@(posedge CLOCK) disable iff (RST)
    IRQ |-> $past(irqctl_q[`AST_IC_GLOBAL] && irqctl_q[`AST_IC_PERIPH]))
    else $error("irq without enables");
  a_port_reset: assert property (@(posedge CLOCK) disable iff (RST)
    !port_on |=> state_q == ast_pkg::AST_IDLE && !hold_full_q) else $error("port not held");

  // pin and status checks; one cycle of register latency is expected everywhere except the same-cycle data length check
  a_lsb_first: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q == ast_pkg::AST_DATA) |=> TX_PIN == $past(shift_q[0])) else $error("data bit order wrong");
  a_data_len: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q == ast_pkg::AST_DATA) |-> bit_cnt_q <= last_bit) else $error("too many data bits");
  a_start_load: assert property (@(posedge CLOCK) disable iff (RST)
    load_q && tx_on && (state_q == ast_pkg::AST_IDLE) |=> state_q == ast_pkg::AST_START)
    else $error("load did not start frame");
  a_shempty_ro: assert property (@(posedge CLOCK) disable iff (RST)
    WR && (ADDR == `AST_OFF_TXCTL) |=> txctl_q[`AST_TX_SHEMPTY] == $past(txctl_q[`AST_TX_SHEMPTY]))
    else $error("shifter empty bit written");
  a_shempty_busy: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q != ast_pkg::AST_IDLE) && !WR |=> !txctl_q[`AST_TX_SHEMPTY]) else $error("busy shows empty");
  a_oe_on: assert property (@(posedge CLOCK) disable iff (RST)
    port_on |=> TX_OE) else $error("pin not driven while on");
  a_oe_off: assert property (@(posedge CLOCK) disable iff (RST)
    !port_on |=> !TX_OE) else $error("pin driven while off");
  a_flag_off: assert property (@(posedge CLOCK) disable iff (RST)
    !port_on |=> !empty_flag_q) else $error("flag set while off");
  a_rx_invert: assert property (@(posedge CLOCK) disable iff (RST)
    1'b1 |=> RX_DATA == ($past(rx_sync_q[1]) ^ $past(ratectl_q[`AST_RC_RXINV])))
    else $error("receive polarity wrong");
  a_rdata_idle: assert property (@(posedge CLOCK) disable iff (RST)
    !RD |=> RDATA == 8'h00) else $error("read data without read");

  // main scenarios
  c_frame: cover property (@(posedge CLOCK) frame_done);
  c_x16: cover property (@(posedge CLOCK) frame_done && (ovs_top == 6'h0F));
  c_irq: cover property (@(posedge CLOCK) $rose(IRQ));
  c_back2back: cover property (@(posedge CLOCK) frame_done ##1 load_q);
  c_nine: cover property (@(posedge CLOCK) frame_done && txctl_q[`AST_TX_NINE]);
endmodule : ast_tx

/* sim/ast_remote.sv */
// remote serial device model: frame receiver on the line, level driver on the receive pin
`timescale 1ns/1ps
module ast_remote (
  input  wire logic        CLOCK,
  input  wire logic        TX_PIN,
  input  wire logic [15:0] BIT_CLKS,
  input  wire logic        NINE,
  output logic             RX_PIN
);
  logic [8:0] words [0:15];
  int         count;
  int         line_bad;
  logic [8:0] w;
  initial begin
    RX_PIN = 1'b1;
    count = 0;
    line_bad = 0;
    forever begin
      @(negedge TX_PIN);
      // sample mid-bit so edge jitter of a cycle cannot matter
      repeat (BIT_CLKS / 2) @(posedge CLOCK);
      if (TX_PIN !== 1'b0) line_bad++;
      w = '0;
      for (int i = 0; i < (NINE ? 9 : 8); i++) begin
        repeat (BIT_CLKS) @(posedge CLOCK);
        w[i] = TX_PIN;
      end
      repeat (BIT_CLKS) @(posedge CLOCK);
      if (TX_PIN !== 1'b1) line_bad++;
      words[count[3:0]] = w;
      count++;
    end
  end
  task automatic drive_rx(input logic v);
    RX_PIN <= v;
  endtask : drive_rx
endmodule : ast_remote

/* sim/tb_async_serial_transmitter.sv */
// register-level tests of the serial transmitter against the remote device model
`timescale 1ns/1ps
`include "ast_cfg.svh"
module tb_async_serial_transmitter;
  logic       CLOCK = 1'b0;
  logic       RST;
  logic [2:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic [7:0] RDATA;
  logic       RX_PIN;
  logic       RX_DATA;
  logic       TX_PIN;
  logic       TX_OE;
  logic       TIMING_PIN;
  logic       IRQ;
  logic [15:0] bit_clks;
  logic       nine;
  logic [7:0] rv;
  int         err_count = 0;
  int         comparisons = 0;
  always #12.5 CLOCK = ~CLOCK;
  ast_tx dut_u (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_PIN(RX_PIN), .RX_DATA(RX_DATA), .TX_PIN(TX_PIN), .TX_OE(TX_OE), .TIMING_PIN(TIMING_PIN), .IRQ(IRQ));
  ast_remote far_u (.CLOCK(CLOCK), .TX_PIN(TX_PIN), .BIT_CLKS(bit_clks), .NINE(nine), .RX_PIN(RX_PIN));
  task automatic conclude;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_pin(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask : rd
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(what, {1'b0, exp}, {1'b0, rv});
  endtask : rdchk
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : tick
  task automatic wait_frames(input int n);
    int i;
    for (i = 0; i < 4000 && far_u.count < n; i++) @(posedge CLOCK);
    if (far_u.count < n) begin
      err_count++;
      $display("BAD frame count expected %0d seen %0d", n, far_u.count);
      conclude();
    end
  endtask : wait_frames
  task automatic wait_empty;
    int i;
    rv = 8'h00;
    for (i = 0; i < 100 && rv[`AST_FL_TXEMPTY] !== 1'b1; i++) rd(`AST_OFF_FLAGS);
    chk_pin("empty flag after load", 1'b1, rv[`AST_FL_TXEMPTY]);
    if (rv[`AST_FL_TXEMPTY] !== 1'b1) conclude();
  endtask : wait_empty
  initial begin
    repeat (100000) @(posedge CLOCK);
    err_count++;
    conclude();
  end
  initial begin
    RST = 1'b1;
    ADDR = 3'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    bit_clks = 16'h0040;
    nine = 1'b0;
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    rdchk(`AST_OFF_TXCTL, `AST_TXCTL_RST, "txctl reset");
    rdchk(`AST_OFF_FLAGS, 8'h00, "flags port off");
    chk_pin("tx idle", 1'b1, TX_PIN);
    chk_pin("oe off", 1'b0, TX_OE);
    wr(`AST_OFF_DIVLO, 8'h00);
    wr(`AST_OFF_DIVHI, 8'h00);
    wr(`AST_OFF_RATECTL, 8'h80);
    wr(`AST_OFF_TXCTL, 8'h20);
    tick(1);
    chk_pin("oe async", 1'b1, TX_OE);
    rdchk(`AST_OFF_FLAGS, 8'h10, "flag on enable");
    wr(`AST_OFF_FLAGS, 8'h00);
    rdchk(`AST_OFF_FLAGS, 8'h10, "flag not clearable");
    rdchk(`AST_OFF_TXCTL, 8'h22, "shifter empty");
    wr(`AST_OFF_HOLD, 8'hA5);
    wait_empty();
    rdchk(`AST_OFF_TXCTL, 8'h20, "shifter busy");
    wr(`AST_OFF_HOLD, 8'h3C);
    tick(2);
    rdchk(`AST_OFF_FLAGS, 8'h00, "flag after write");
    wait_frames(2);
    chk("word 0 x64", 9'h0A5, far_u.words[0]);
    chk("word 1 queued", 9'h03C, far_u.words[1]);
    // stop bit lasts half a bit time more after the model samples its middle
    tick(64);
    rdchk(`AST_OFF_TXCTL, 8'h22, "shifter drained");
    $display("test frames done");
    nine <= 1'b1;
    wr(`AST_OFF_TXCTL, 8'h61);
    wr(`AST_OFF_HOLD, 8'h5A);
    wait_frames(3);
    chk("nine bit word", 9'h15A, far_u.words[2]);
    tick(64);
    nine <= 1'b0;
    bit_clks <= 16'h0020;
    wr(`AST_OFF_DIVLO, 8'h01);
    wr(`AST_OFF_TXCTL, 8'h24);
    wr(`AST_OFF_HOLD, 8'hC3);
    wait_frames(4);
    chk("word x16 narrow", 9'h0C3, far_u.words[3]);
    tick(32);
    wr(`AST_OFF_TXCTL, 8'h20);
    wr(`AST_OFF_RATECTL, 8'h88);
    wr(`AST_OFF_HOLD, 8'h81);
    wait_frames(5);
    chk("word x16 wide", 9'h081, far_u.words[4]);
    chk("line framing errors", 9'h000, far_u.line_bad[8:0]);
    $display("test rates done");
    wr(`AST_OFF_RATECTL, 8'h98);
    tick(2);
    chk_pin("timing idle high", 1'b1, TIMING_PIN);
    wr(`AST_OFF_RATECTL, 8'h88);
    tick(2);
    chk_pin("timing idle low", 1'b0, TIMING_PIN);
    far_u.drive_rx(1'b0);
    tick(4);
    chk_pin("rx plain", 1'b0, RX_DATA);
    wr(`AST_OFF_RATECTL, 8'hA8);
    tick(4);
    chk_pin("rx inverted", 1'b1, RX_DATA);
    $display("test pins done");
    wr(`AST_OFF_PIE, 8'h10);
    wr(`AST_OFF_IRQCTL, 8'h80);
    tick(2);
    chk_pin("irq global only", 1'b0, IRQ);
    wr(`AST_OFF_IRQCTL, 8'hC0);
    tick(2);
    chk_pin("irq both", 1'b1, IRQ);
    wr(`AST_OFF_PIE, 8'h00);
    tick(2);
    chk_pin("irq masked", 1'b0, IRQ);
    rdchk(`AST_OFF_FLAGS, 8'h10, "flag while masked");
    wr(`AST_OFF_TXCTL, 8'h30);
    tick(2);
    chk_pin("oe sync", 1'b0, TX_OE);
    wr(`AST_OFF_RATECTL, 8'h00);
    tick(2);
    chk_pin("oe port off", 1'b0, TX_OE);
    rdchk(`AST_OFF_FLAGS, 8'h00, "flag port off");
    $display("test control done");
    conclude();
  end
endmodule : tb_async_serial_transmitter
